// ===== adc_analog_model.sv
// analogue side model: per-channel input level, sample-and-hold, comparator
// assumes trialCode settles between converter ticks; levels above 0x3ff exceed the reference
`default_nettype none
module adc_analog_model (
    // clock
    input  wire logic        clock,
    // controls from the sequencer
    input  wire logic [4:0]  channelSelect,
    input  wire logic        sampleEnable,
    input  wire logic [9:0]  trialCode,
    // input levels per channel, in result units
    input  wire logic [10:0] level [32],
    // comparator
    output logic             compAbove
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] held = 11'h000;

    // tracks the selected input while the switch is closed, holds after
    always_ff @(posedge clock) begin
        if (sampleEnable) begin
            held <= level[channelSelect];
        end
    end

    // no wraparound: anything at or above full scale stays above every trial
    assign compAbove = ({1'b0, trialCode} <= held);
endmodule : adc_analog_model
`default_nettype wire

// ===== adc_conversion_sequencer.sv
// converter sequencer: registers, sampling window, conversion timing
// assumes a synchronous register master and a comparator settled per tick
`default_nettype none
module adc_conversion_sequencer (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // register port
    input  wire logic [4:0] regAddr,
    input  wire logic [7:0] regWriteData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic [7:0]      regReadData,
    // analogue side
    input  wire logic       compAbove,
    output logic [9:0]      trialCode,
    output logic            sampleEnable,
    output logic [4:0]      channelSelect,
    output logic [1:0]      referenceSelect,
    output logic            tempSensorOn,
    output logic            samplingCapacitorSelect,
    output logic            analogEnable
);
    typedef enum logic [2:0] {IDLE, INIT_WAIT, SAMPLE, CONVERT, FINISH} phase_t;

    typedef struct packed {
        phase_t     phase;
        logic [7:0] count;
        logic       enable;
        logic       freeRun;
        logic       capSelect;
        logic [2:0] presc;
        logic [2:0] initialDelay;
        logic [3:0] sampleDelayCount;
        logic [4:0] sampleLengthCount;
        logic [1:0] refShadow;
        logic [4:0] chanShadow;
        logic [1:0] refActive;
        logic [4:0] chanActive;
        logic       tempOn;
        logic       startBit;
        logic       firstRun;
        logic       resultReady;
        logic [9:0] result;
        logic       sampleOn;
        logic       done;
        logic [7:0] readData;
    } seq_state_t;

    seq_state_t s_reg;
    seq_state_t s_next;
    logic       tick;
    logic       sarLoad;
    logic       sarStep;
    logic       finishNow;
    logic [7:0] windowLen;

    adc_prescaler prescaler (
        .clock (clock),
        .rst   (rst),
        .run   (s_reg.startBit && s_reg.enable),
        .presc (s_reg.presc),
        .tick  (tick)
    );

    adc_sar_register sar (
        .clock     (clock),
        .rst       (rst),
        .load      (sarLoad),
        .step      (sarStep),
        .compAbove (compAbove),
        .trialCode (trialCode)
    );

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.readData = 8'h00;
        sarLoad = 1'b0;
        sarStep = 1'b0;
        windowLen = adc_seq_pkg::window_len(s_reg.sampleDelayCount, s_reg.sampleLengthCount);
        finishNow = (s_reg.phase == FINISH) && tick;

        // software writes; selects go to shadows only
        if (regWrite) begin
            case (regAddr)
                adc_seq_pkg::CONTROL_OFFSET: begin
                    s_next.enable = regWriteData[adc_seq_pkg::ENABLE_BIT];
                    s_next.freeRun = regWriteData[adc_seq_pkg::FREERUN_BIT];
                end
                adc_seq_pkg::REFERENCE_OFFSET: begin
                    s_next.capSelect = regWriteData[adc_seq_pkg::CAPACITOR_BIT];
                    s_next.refShadow = regWriteData[adc_seq_pkg::REFERENCE_LSB +: 2];
                    s_next.presc = regWriteData[2:0];
                end
                adc_seq_pkg::DELAY_OFFSET: begin
                    s_next.initialDelay = regWriteData[adc_seq_pkg::INITIAL_DELAY_LSB +: 3];
                    s_next.sampleDelayCount = regWriteData[3:0];
                end
                adc_seq_pkg::LENGTH_OFFSET: begin
                    s_next.sampleLengthCount = regWriteData[4:0];
                end
                adc_seq_pkg::CHANNEL_OFFSET: begin
                    s_next.chanShadow = regWriteData[4:0];
                end
                adc_seq_pkg::COMMAND_OFFSET: begin
                    if (regWriteData[adc_seq_pkg::START_BIT] && s_reg.enable) begin
                        s_next.startBit = 1'b1;
                    end
                end
                adc_seq_pkg::FLAGS_OFFSET: begin
                    if (regWriteData[adc_seq_pkg::READY_BIT]) begin
                        s_next.resultReady = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // reads answer one cycle later; unmapped addresses read zero
        if (regRead) begin
            case (regAddr)
                adc_seq_pkg::CONTROL_OFFSET: s_next.readData = {6'h00, s_reg.freeRun, s_reg.enable};
                adc_seq_pkg::REFERENCE_OFFSET: s_next.readData = {1'b0, s_reg.capSelect,
                    s_reg.refShadow, 1'b0, s_reg.presc};
                adc_seq_pkg::DELAY_OFFSET: s_next.readData = {s_reg.initialDelay, 1'b0,
                    s_reg.sampleDelayCount};
                adc_seq_pkg::LENGTH_OFFSET: s_next.readData = {3'h0, s_reg.sampleLengthCount};
                adc_seq_pkg::CHANNEL_OFFSET: s_next.readData = {3'h0, s_reg.chanShadow};
                adc_seq_pkg::COMMAND_OFFSET: s_next.readData = {7'h00, s_reg.startBit};
                adc_seq_pkg::FLAGS_OFFSET: s_next.readData = {7'h00, s_reg.resultReady};
                adc_seq_pkg::RESULT_LO_OFFSET: begin
                    s_next.readData = s_reg.result[7:0];
                    s_next.resultReady = 1'b0;
                end
                adc_seq_pkg::RESULT_HI_OFFSET: begin
                    s_next.readData = {6'h00, s_reg.result[9:8]};
                    s_next.resultReady = 1'b0;
                end
                default: s_next.readData = 8'h00;
            endcase
        end

        case (s_reg.phase)
            IDLE: begin
                if (s_reg.startBit && tick) begin
                    // this tick is the first converter edge after the start write
                    s_next.firstRun = 1'b0;
                    if (s_reg.firstRun && s_reg.initialDelay != 3'h0) begin
                        s_next.phase = INIT_WAIT;
                        s_next.count = 8'(s_reg.initialDelay) * adc_seq_pkg::INIT_DELAY_UNIT - 8'h01;
                    end else begin
                        s_next.phase = SAMPLE;
                        s_next.count = windowLen - 8'h01;
                        s_next.sampleOn = 1'b1;
                    end
                end
            end
            INIT_WAIT: begin
                if (tick) begin
                    if (s_reg.count == 8'h00) begin
                        s_next.phase = SAMPLE;
                        s_next.count = windowLen - 8'h01;
                        s_next.sampleOn = 1'b1;
                    end else begin
                        s_next.count = s_reg.count - 8'h01;
                    end
                end
            end
            SAMPLE: begin
                if (tick) begin
                    if (s_reg.count == 8'h00) begin
                        // hold the input, then ten bit decisions
                        s_next.phase = CONVERT;
                        s_next.count = adc_seq_pkg::BIT_CYCLES - 8'h01;
                        s_next.sampleOn = 1'b0;
                        sarLoad = 1'b1;
                    end else begin
                        s_next.count = s_reg.count - 8'h01;
                    end
                end
            end
            CONVERT: begin
                if (tick) begin
                    sarStep = 1'b1;
                    if (s_reg.count == 8'h00) begin
                        s_next.phase = FINISH;
                    end else begin
                        s_next.count = s_reg.count - 8'h01;
                    end
                end
            end
            FINISH: begin
                if (tick) begin
                    // flag and data land on one edge, set beats any clear
                    s_next.result = trialCode;
                    s_next.resultReady = 1'b1;
                    s_next.done = 1'b1;
                    if (s_reg.freeRun && s_reg.startBit) begin
                        s_next.phase = SAMPLE;
                        s_next.count = windowLen - 8'h01;
                        s_next.sampleOn = 1'b1;
                    end else begin
                        s_next.phase = IDLE;
                        s_next.startBit = 1'b0;
                    end
                end
            end
            default: s_next.phase = IDLE;
        endcase

        // selects follow shadows except while a conversion holds them
        if (s_reg.phase == IDLE || s_reg.phase == INIT_WAIT || s_reg.phase == FINISH) begin
            s_next.chanActive = s_reg.chanShadow;
            s_next.refActive = s_reg.refShadow;
        end
        s_next.tempOn = (s_next.chanActive == adc_seq_pkg::TEMP_CHANNEL);

        // disabled: sequencer idle, a pending start is dropped
        if (!s_reg.enable) begin
            s_next.phase = IDLE;
            s_next.count = 8'h00;
            s_next.startBit = 1'b0;
            s_next.sampleOn = 1'b0;
            s_next.firstRun = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.phase <= IDLE;
            s_reg.firstRun <= 1'b1;
            s_reg.refShadow <= adc_seq_pkg::REFERENCE_RESET;
            s_reg.refActive <= adc_seq_pkg::REFERENCE_RESET;
            s_reg.chanShadow <= adc_seq_pkg::CHANNEL_RESET;
            s_reg.chanActive <= adc_seq_pkg::CHANNEL_RESET;
            s_reg.result <= adc_seq_pkg::RESULT_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign regReadData = s_reg.readData;
    assign sampleEnable = s_reg.sampleOn;
    assign channelSelect = s_reg.chanActive;
    assign referenceSelect = s_reg.refActive;
    assign tempSensorOn = s_reg.tempOn;
    assign samplingCapacitorSelect = s_reg.capSelect;
    assign analogEnable = s_reg.enable;

    // helper: converter cycles since sampling of the current conversion began
    logic [7:0] tickCount;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tickCount <= 8'h00;
        end else if (finishNow || s_reg.phase == IDLE) begin
            tickCount <= 8'h00;
        end else if (tick && s_reg.phase != INIT_WAIT) begin
            tickCount <= tickCount + 8'h01;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sample_window_a: assert property ($fell(sampleEnable) && s_reg.enable |->
        tickCount == windowLen)
        else $error("sampling window length wrong");
    period_length_a: assert property (finishNow |->
        tickCount + 8'h01 == adc_seq_pkg::CONVERSION_CYCLES + windowLen - 8'h02)
        else $error("conversion period length wrong");
    free_restart_a: assert property (finishNow && s_reg.freeRun && s_reg.startBit
        && s_reg.enable |=> sampleEnable && s_reg.startBit)
        else $error("free-running restart missing");
    single_clear_a: assert property (finishNow && !s_reg.freeRun && s_reg.enable |=>
        !s_reg.startBit ##0 s_reg.resultReady)
        else $error("single conversion end wrong");
    select_lock_a: assert property ((s_reg.phase == SAMPLE || s_reg.phase == CONVERT)
        |=> $stable(channelSelect) && $stable(referenceSelect))
        else $error("selects moved during conversion");
    shadow_follow_a: assert property (s_reg.phase == IDLE |=>
        channelSelect == $past(s_reg.chanShadow))
        else $error("active channel not following shadow");
    result_with_flag_a: assert property ($changed(s_reg.result) |->
        s_reg.done && s_reg.resultReady)
        else $error("result changed without ready flag");
    read_clear_a: assert property (regRead && regAddr == adc_seq_pkg::RESULT_LO_OFFSET
        && !finishNow |=> !s_reg.resultReady)
        else $error("result read did not clear flag");
    temp_sensor_a: assert property (tempSensorOn ==
        (channelSelect == adc_seq_pkg::TEMP_CHANNEL))
        else $error("temperature sensor enable mismatch");
    start_edge_a: assert property (s_reg.phase == IDLE && s_reg.startBit && tick
        && s_reg.enable |=> s_reg.phase != IDLE)
        else $error("conversion did not begin on tick");
    presc_hold_a: assert property (!s_reg.startBit [*2] |-> !tick)
        else $error("prescaler ran while idle");

    single_done_c: cover property (s_reg.done && !s_reg.freeRun);
    free_run_c: cover property (s_reg.done ##[1:1000] s_reg.done && s_reg.freeRun);
    read_clear_c: cover property (s_reg.resultReady ##1 !s_reg.resultReady);
    temp_measure_c: cover property (tempSensorOn && sampleEnable);
endmodule : adc_conversion_sequencer
`default_nettype wire

// ===== adc_conversion_sequencer_tb_top.sv
// random-stimulus testbench for the converter sequencer
// assumes prescaler field 0, so one converter tick is two clocks
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fails++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module adc_conversion_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0;
    logic        rst;
    logic [4:0]  regAddr;
    logic [7:0]  regWriteData;
    logic        regWrite;
    logic        regRead;
    logic [7:0]  regReadData;
    logic        compAbove;
    logic [9:0]  trialCode;
    logic        sampleEnable;
    logic [4:0]  channelSelect;
    logic [1:0]  referenceSelect;
    logic        tempSensorOn;
    logic        samplingCapacitorSelect;
    logic        analogEnable;
    logic [10:0] level [32];
    int          seed = 87;
    int          fails = 0;
    int          checks = 0;

    always #5 clock = ~clock;

    adc_conversion_sequencer adc_conversion_sequencer_inst (
        .clock(clock), .rst(rst), .regAddr(regAddr), .regWriteData(regWriteData),
        .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
        .compAbove(compAbove), .trialCode(trialCode), .sampleEnable(sampleEnable),
        .channelSelect(channelSelect), .referenceSelect(referenceSelect),
        .tempSensorOn(tempSensorOn), .samplingCapacitorSelect(samplingCapacitorSelect),
        .analogEnable(analogEnable));

    adc_analog_model adc_analog_model_inst (
        .clock(clock), .channelSelect(channelSelect), .sampleEnable(sampleEnable),
        .trialCode(trialCode), .level(level), .compAbove(compAbove));

    function automatic logic [9:0] exp_code(input logic [10:0] v);
        return (v > 11'h3ff) ? 10'h3ff : v[9:0];
    endfunction : exp_code

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    // every bus task starts and ends just after a rising edge
    // a spare edge after each transfer keeps two strobe assignments apart
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        @(posedge clock);
        d = regReadData;
    endtask : rd

    task automatic wait_sample(input logic v, output int n);
        n = 0;
        while (sampleEnable !== v) begin
            @(posedge clock);
            n++;
            if (n > 3000) begin fails++; complete_run(); end
        end
    endtask : wait_sample

    // polls the flag register, which a read leaves untouched
    task automatic wait_ready();
        logic [7:0] d;
        int k;
        d = 8'h00;
        k = 0;
        while (d[0] !== 1'b1) begin
            rd(adc_seq_pkg::FLAGS_OFFSET, d);
            k++;
            if (k > 500) begin fails++; complete_run(); end
        end
    endtask : wait_ready

    task automatic get_result(output logic [9:0] r);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(adc_seq_pkg::RESULT_LO_OFFSET, lo);
        rd(adc_seq_pkg::RESULT_HI_OFFSET, hi);
        r = {hi[1:0], lo};
    endtask : get_result

    task automatic convert(input logic fr, input logic corner, input logic [2:0] idl);
        logic [4:0] ch;
        logic [3:0] dly;
        logic [4:0] len;
        logic [7:0] d;
        logic [9:0] r;
        int         n;
        int         m;
        ch = 5'($random(seed));
        dly = 4'($random(seed));
        len = 5'($random(seed));
        level[ch] = corner ? 11'h400 : 11'($random(seed));
        level[ch ^ 5'h01] = 11'($random(seed));
        wr(adc_seq_pkg::CHANNEL_OFFSET, {3'h0, ch});
        wr(adc_seq_pkg::DELAY_OFFSET, {idl, 1'b0, dly});
        wr(adc_seq_pkg::LENGTH_OFFSET, {3'h0, len});
        wr(adc_seq_pkg::CONTROL_OFFSET, {6'h00, fr, 1'b1});
        wr(adc_seq_pkg::COMMAND_OFFSET, 8'h01);
        rd(adc_seq_pkg::COMMAND_OFFSET, d);
        `CHK("start busy", 8'h01, d)
        // zero extra clocks unless a first-run initial delay is programmed
        wait_sample(1'b1, n);
        `CHK("initial wait", 2 * adc_seq_pkg::INIT_DELAY_UNIT * idl, n)
        wr(adc_seq_pkg::CHANNEL_OFFSET, {3'h0, ch ^ 5'h01});
        `CHK("frozen channel", ch, channelSelect)
        wait_sample(1'b0, n);
        // two clocks of the channel write lie outside n
        `CHK("window clocks", 2 * (2 + dly + len), n + 2)
        if (fr) begin
            wait_sample(1'b1, m);
            `CHK("free-run period", 2 * (13 + dly + len), n + 2 + m)
        end
        wait_ready();
        `CHK("channel resumed", ch ^ 5'h01, channelSelect)
        get_result(r);
        `CHK("result", exp_code(level[ch]), r)
        rd(adc_seq_pkg::FLAGS_OFFSET, d);
        `CHK("ready cleared", 8'h00, d)
        if (fr) begin
            wait_ready();
            get_result(r);
            `CHK("next result", exp_code(level[ch ^ 5'h01]), r)
            wr(adc_seq_pkg::CONTROL_OFFSET, 8'h00);
        end else begin
            rd(adc_seq_pkg::COMMAND_OFFSET, d);
            `CHK("start cleared", 8'h00, d)
        end
    endtask : convert

    initial begin
        logic [7:0] d;
        for (int c = 0; c < 32; c++) level[c] = 11'h000;
        regAddr = 5'h00;
        regWriteData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        rst = 1'b1;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        `CHK("channel at reset", 5'h00, channelSelect)
        `CHK("result bus at reset", 8'h00, regReadData)
        wr(adc_seq_pkg::CONTROL_OFFSET, 8'h01);
        `CHK("enable", 1'b1, analogEnable)
        for (int r = 0; r < 3; r++) begin
            wr(adc_seq_pkg::REFERENCE_OFFSET, {2'b01, 2'(r), 4'h0});
            wr(adc_seq_pkg::CHANNEL_OFFSET, {3'h0, adc_seq_pkg::TEMP_CHANNEL ^ 5'(r)});
            repeat (3) @(posedge clock);
            `CHK("reference", 2'(r), referenceSelect)
            `CHK("capacitor", 1'b1, samplingCapacitorSelect)
            `CHK("sensor", (r == 0), tempSensorOn)
        end
        rd(5'h07, d);
        `CHK("unmapped read", 8'h00, d)
        $display("test setup done");
        for (int i = 0; i < 6; i++) begin
            convert(i[0], i == 0, 3'(i == 2));
            $display("test conversion %0d done", i);
        end
        complete_run();
    end
endmodule : adc_conversion_sequencer_tb_top
`default_nettype wire

// ===== adc_prescaler.sv
// converter clock prescaler: one-cycle tick every 2 << presc clocks
// assumes run drops whenever no conversion is pending
`default_nettype none
module adc_prescaler (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // control
    input  wire logic       run,
    input  wire logic [2:0] presc,
    // converter clock edge
    output logic            tick
);
    typedef struct packed {
        logic [7:0] count;
        logic       tick;
    } presc_state_t;

    presc_state_t s_reg;
    presc_state_t s_next;
    logic [7:0]   lastCount;

    always_comb begin
        s_next = s_reg;
        lastCount = 8'((9'h002 << presc) - 9'h001);
        if (!run) begin
            // held in reset keeps the start delay fixed
            s_next.count = 8'h00;
            s_next.tick = 1'b0;
        end else begin
            s_next.count = (s_reg.count == lastCount) ? 8'h00 : s_reg.count + 8'h01;
            s_next.tick = (s_reg.count == lastCount - 8'h01)
                || (lastCount == 8'h01 && s_reg.count == 8'h00);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;
endmodule : adc_prescaler
`default_nettype wire

// ===== adc_sar_register.sv
// successive approximation register, one bit decided per step
// assumes compAbove is settled for the trial code when step comes
`default_nettype none
module adc_sar_register (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // control
    input  wire logic       load,
    input  wire logic       step,
    input  wire logic       compAbove,
    // trial code towards the analogue side
    output logic [9:0]      trialCode
);
    typedef struct packed {
        logic [9:0] code;
        logic [9:0] mask;
    } sar_state_t;

    sar_state_t s_reg;
    sar_state_t s_next;

    always_comb begin
        s_next = s_reg;
        if (load) begin
            s_next.code = adc_seq_pkg::SAR_FIRST_TRIAL;
            s_next.mask = adc_seq_pkg::SAR_FIRST_TRIAL;
        end else if (step && s_reg.mask != 10'h000) begin
            // no carry out: an input above reference settles at all ones
            s_next.code = (compAbove ? s_reg.code : (s_reg.code & ~s_reg.mask))
                | (s_reg.mask >> 1);
            s_next.mask = s_reg.mask >> 1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign trialCode = s_reg.code;
endmodule : adc_sar_register
`default_nettype wire

// ===== adc_seq_pkg.sv
// constants, register map and timing figures of the converter sequencer
// assumes one clock domain; converter cycles come from the prescaler tick
// Functional notes
// - sampling lasts two plus delay plus length
// - free-running restarts directly while start bit set
// - free-running period thirteen plus delay plus length
// - selects written into freely accessible shadows
// - selects freeze during conversion, copy at finish
// - conversion begins on next converter clock edge
// - mid-run channel change affects the following result
// - input above reference gives code 3ff
// - reference is supply, external pin or internal
// - result equals input times 1023 over reference
// - temperature channel select switches sensor on
// - plain conversion thirteen cycles, sample after two
// - start bit reads one, single mode clears it
// - ready flag set at finish, cleared by read/write-one
// - prescaler held in reset while idle
`default_nettype none
package adc_seq_pkg;
    // register offsets
    localparam logic [4:0] CONTROL_OFFSET   = 5'h00;
    localparam logic [4:0] REFERENCE_OFFSET = 5'h02;
    localparam logic [4:0] DELAY_OFFSET     = 5'h03;
    localparam logic [4:0] LENGTH_OFFSET    = 5'h05;
    localparam logic [4:0] CHANNEL_OFFSET   = 5'h06;
    localparam logic [4:0] COMMAND_OFFSET   = 5'h08;
    localparam logic [4:0] FLAGS_OFFSET     = 5'h0b;
    localparam logic [4:0] RESULT_LO_OFFSET = 5'h10;
    localparam logic [4:0] RESULT_HI_OFFSET = 5'h11;
    // field positions
    localparam int ENABLE_BIT        = 0;
    localparam int FREERUN_BIT       = 1;
    localparam int START_BIT         = 0;
    localparam int READY_BIT         = 0;
    localparam int CAPACITOR_BIT     = 6;
    localparam int REFERENCE_LSB     = 4;
    localparam int INITIAL_DELAY_LSB = 5;
    // reference select codes
    localparam logic [1:0] REF_INTERNAL = 2'h0;
    localparam logic [1:0] REF_SUPPLY   = 2'h1;
    localparam logic [1:0] REF_EXTERNAL = 2'h2;
    // reset values
    localparam logic [1:0] REFERENCE_RESET = REF_INTERNAL;
    localparam logic [4:0] CHANNEL_RESET   = 5'h00;
    localparam logic [9:0] RESULT_RESET    = 10'h000;
    // channel code of the on-chip temperature sensor
    localparam logic [4:0] TEMP_CHANNEL = 5'h1e;
    // timing in converter cycles, then the first SAR trial code
    localparam logic [7:0] FIXED_SAMPLE_CYCLES = 8'h02;
    localparam logic [7:0] BIT_CYCLES          = 8'h0a;
    localparam logic [7:0] CONVERSION_CYCLES   = 8'h0d;
    localparam logic [7:0] INIT_DELAY_UNIT     = 8'h10;
    localparam logic [9:0] SAR_FIRST_TRIAL     = 10'h200;

    function automatic logic [7:0] window_len(input logic [3:0] dly, input logic [4:0] len);
        window_len = FIXED_SAMPLE_CYCLES + {4'h0, dly} + {3'h0, len};
    endfunction : window_len
endpackage : adc_seq_pkg
`default_nettype wire
